// [core/mft_pkg.sv]
// Package: register map, field layouts and constants of the timer block
package mft_pkg;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_CNT1 = 8'h00;
  localparam logic [7:0] OFF_CRA = 8'h04;
  localparam logic [7:0] OFF_CRB = 8'h08;
  localparam logic [7:0] OFF_CNT2 = 8'h0C;
  localparam logic [7:0] OFF_PRSC = 8'h10;
  localparam logic [7:0] OFF_CKC = 8'h14;
  localparam logic [7:0] OFF_MCTRL = 8'h18;
  localparam logic [7:0] OFF_ICTRL = 8'h1C;
  localparam logic [7:0] OFF_ICLR = 8'h20;

  // ------------------------------------------------------------------
  // Mode control field positions
  // ------------------------------------------------------------------
  localparam int MC_MODE_LSB = 0;   // 3-bit mode code
  localparam int MC_EN = 3;         // module enable
  localparam int MC_AEN = 4;        // primary pin enable
  localparam int MC_BEN = 5;        // secondary pin enable
  localparam int MC_AOUT = 6;       // primary output level
  localparam int MC_PTSE = 7;       // pulse-train start
  localparam int MC_AEDG = 8;       // primary edge: 1 rising
  localparam int MC_BEDG = 9;       // secondary edge: 1 rising
  localparam logic [9:0] MC_MASK = 10'h3FF;

  // Interrupt control: enables A..D in bits 3:0, pending A..D in 7:4
  localparam int IC_PND_LSB = 4;

  // Clock select field positions and codes
  localparam int CK_C1_LSB = 0;
  localparam int CK_C2_LSB = 3;
  localparam logic [2:0] CS_NONE = 3'h0;
  localparam logic [2:0] CS_PRSC = 3'h1;
  localparam logic [2:0] CS_EXT = 3'h2;
  localparam logic [2:0] CS_PACC = 3'h3;

  localparam logic [15:0] PRESET_VAL = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_1 = 3'h0,
    MODE_2 = 3'h1,
    MODE_3 = 3'h2,
    MODE_4 = 3'h3,
    MODE_1A = 3'h4
  } mode_t;

endpackage : mft_pkg

// [core/mft_unit.sv]
// One multifunction timer instance with APB register slave
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Primary pin toggles on counter one underflow, except in mode 2
// - Mode 2 primary edge captures, optional preset
// - Modes 1,3 secondary pin clocks counters
// - Mode 1a secondary event only without start
// - Mode 2 secondary edge captures into A/B
// - Mode 4 secondary edge captures counter two
// - Capture counter waits for first input event
// - Waveform appears on instance waveform pad
// - Four sources, each pending and enable
// - A,B,C to line one; D line two
// - Flag A: reload from A or capture
// - Flag B: reload from B or capture
// - Flag C only mode 2 underflow
// - Flag D: counter two underflow/reload
// - Instances decode identical registers separately
// - Nine word registers, offsets zero to 0x20
// - Counter one 16 bit, not reset, live
// - Reload A writable only when enabled
// - Output level bit sets pin level
// - Capture first, then preset all ones
module mft_unit import mft_pkg::*; #(
  parameter int CNT_W = 16  // counter width
) (
  input wire logic pclk,             // System clock
  input wire logic presetn,          // Async reset, active low
  input wire logic psel,             // APB select
  input wire logic penable,          // APB enable
  input wire logic pwrite,           // APB direction
  input wire logic [7:0] paddr,      // APB byte address
  input wire logic [31:0] pwdata,    // APB write data
  output logic [31:0] prdata,        // APB read data
  output logic pready,               // APB ready
  output logic pslverr,              // APB error
  input wire logic primary_timer_pin_i,    // Primary pin input
  output logic primary_timer_pin_o,        // Primary pin output
  output logic primary_timer_pin_oe,       // Primary pin drive enable
  input wire logic secondary_timer_pin_i,  // Secondary pin input
  output logic irq_line_one,         // Sources A,B,C
  output logic irq_line_two          // Source D
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [CNT_W-1:0] counter_one_q, counter_two_q;
  logic [CNT_W-1:0] reload_register_a_q, reload_register_b_q;
  logic [7:0] prescaler_value_q, presc_cnt_q;
  logic [5:0] clock_mode_select_q;
  logic [9:0] mode_control_bits_q;
  logic [3:0] source_interrupt_enable_q;
  logic [3:0] pending_q;
  logic pin_level_q;
  logic a_prev_q, b_prev_q;
  logic armed1_q, armed2_q;    // capture counters started
  logic sel1_q;                // next reload source, counter one
  logic ptse_q;
  mode_t mode;
  // Counter and reload contents keep no reset value: software must
  // load them before it selects a clock, or the first underflow and
  // the flags it sets are unknown

  // ------------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------------
  // Clock tick for a counter from its clock select code
  function automatic logic tick_of(input logic [2:0] cs, input logic pre,
                                   input logic ext, input logic lvl,
                                   input logic ext_ok);
    case (cs)
      CS_PRSC: tick_of = pre;
      CS_EXT: tick_of = ext & ext_ok;
      CS_PACC: tick_of = lvl & ext_ok;
      default: tick_of = 1'b0;
    endcase
  endfunction : tick_of

  // Edge selected by polarity bit (1 rising, 0 falling)
  function automatic logic edge_of(input logic cur, input logic prev,
                                   input logic rise);
    edge_of = rise ? (cur & ~prev) : (~cur & prev);
  endfunction : edge_of

  // Mode field read straight from the control register
  assign mode = mode_t'(mode_control_bits_q[MC_MODE_LSB +: 3]);

  // Control bits used throughout
  logic en, aen, ben;
  assign en = mode_control_bits_q[MC_EN];
  assign aen = mode_control_bits_q[MC_AEN];
  assign ben = mode_control_bits_q[MC_BEN];

  // ------------------------------------------------------------------
  // Pin events and counter ticks
  // ------------------------------------------------------------------
  // Event and strobe nets
  logic a_edge, b_edge, pre_tick, ext_ok, tick1, tick2;
  logic uf1, uf2, cap_a, cap_b, cap_b2, pre1, pre2;
  logic wr, rd_en;
  // Writes land at the access edge; reads latch at setup
  assign wr = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  // Pin history resets low, the idle level of both pads, so no
  // false edge follows reset
  assign a_edge = edge_of(primary_timer_pin_i, a_prev_q,
                          mode_control_bits_q[MC_AEDG]);
  assign b_edge = edge_of(secondary_timer_pin_i, b_prev_q,
                          mode_control_bits_q[MC_BEDG]);
  // Prescaler tick only while the module is enabled
  assign pre_tick = en && (presc_cnt_q == 8'h00);
  // Secondary pin is an event input in modes 1,3; 1a only idle
  assign ext_ok = en && ((mode == MODE_1) || (mode == MODE_3) ||
                  ((mode == MODE_1A) && !ptse_q));
  // Capture counters hold off until first input event
  assign tick1 = tick_of(clock_mode_select_q[CK_C1_LSB +: 3], pre_tick,
                         b_edge, secondary_timer_pin_i, ext_ok) &&
                 (mode != MODE_2 || armed1_q);
  assign tick2 = tick_of(clock_mode_select_q[CK_C2_LSB +: 3], pre_tick,
                         b_edge, secondary_timer_pin_i, ext_ok) &&
                 (mode != MODE_4 || armed2_q);
  // Underflow: a tick while the count stands at zero
  assign uf1 = tick1 && (counter_one_q == CNT_ZERO);
  assign uf2 = tick2 && (counter_two_q == CNT_ZERO);
  // Mode 2 primary edge: capture to A, preset if enabled
  assign cap_a = en && (mode == MODE_2) && (a_edge || (b_edge && ben));
  assign cap_b = en && (mode == MODE_2) && b_edge && !ben;
  assign cap_b2 = en && (mode == MODE_4) && b_edge;
  // Preset terms; the capture takes the old count at the same edge
  assign pre1 = en && (mode == MODE_2) &&
                ((a_edge && aen) || (b_edge && ben));
  assign pre2 = cap_b2 && ben;

  // ------------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------------
  // One tick every prescaler+1 cycles; held at the reload value while
  // disabled, so a new start always gives a full first period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt_q <= 8'h00;
    end else if (!en || presc_cnt_q == 8'h00) begin
      presc_cnt_q <= prescaler_value_q;
    end else begin
      presc_cnt_q <= presc_cnt_q - 8'h01;
    end
  end

  // Pin history and capture arming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
      armed1_q <= 1'b0;
      armed2_q <= 1'b0;
    end else begin
      a_prev_q <= primary_timer_pin_i;
      b_prev_q <= secondary_timer_pin_i;
      if (!en) begin
        armed1_q <= 1'b0;
        armed2_q <= 1'b0;
      end else begin
        if (cap_a || cap_b) armed1_q <= 1'b1;
        if (cap_b2) armed2_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Counters: no reset, so contents are random after power-up
  // ------------------------------------------------------------------
  // Capture precedes preset in the same edge
  // A software write wins over preset and reload, so a count
  // loaded in the middle of a run is never lost
  always_ff @(posedge pclk) begin
    if (wr && paddr == OFF_CNT1) begin
      counter_one_q <= pwdata[CNT_W-1:0];
    end else if (pre1) begin
      counter_one_q <= PRESET_VAL;
    end else if (uf1) begin
      counter_one_q <= (sel1_q && (mode == MODE_1 || mode == MODE_1A)) ?
                       reload_register_b_q : reload_register_a_q;
    end else if (tick1) begin
      counter_one_q <= counter_one_q - 16'h0001;
    end
  end

  // Counter two reloads from B only; preset wins over underflow
  always_ff @(posedge pclk) begin
    if (wr && paddr == OFF_CNT2) begin
      counter_two_q <= pwdata[CNT_W-1:0];
    end else if (pre2) begin
      counter_two_q <= PRESET_VAL;
    end else if (uf2) begin
      counter_two_q <= reload_register_b_q;
    end else if (tick2) begin
      counter_two_q <= counter_two_q - 16'h0001;
    end
  end

  // Reload registers: writes need module enable
  // A capture wins over a same-cycle software write
  always_ff @(posedge pclk) begin
    if (cap_a) begin
      reload_register_a_q <= counter_one_q;
    end else if (wr && paddr == OFF_CRA && en) begin
      reload_register_a_q <= pwdata[CNT_W-1:0];
    end
  end

  // Reload B: capture from either counter, else a gated write
  always_ff @(posedge pclk) begin
    if (cap_b) begin
      reload_register_b_q <= counter_one_q;
    end else if (cap_b2) begin
      reload_register_b_q <= counter_two_q;
    end else if (wr && paddr == OFF_CRB && en) begin
      reload_register_b_q <= pwdata[CNT_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------
  // Plain control fields; writes to other offsets fall through
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler_value_q <= 8'h00;
      clock_mode_select_q <= 6'h00;
      mode_control_bits_q <= 10'h000;
      source_interrupt_enable_q <= 4'h0;
    end else if (wr) begin
      case (paddr)
        OFF_PRSC: prescaler_value_q <= pwdata[7:0];
        OFF_CKC: clock_mode_select_q <= pwdata[5:0];
        OFF_MCTRL: mode_control_bits_q <= pwdata[9:0] & MC_MASK;
        OFF_ICTRL: source_interrupt_enable_q <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Pulse-train start: cleared by writing, or by hardware on disable
  // Limitation: only taken once mode 1a is already selected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptse_q <= 1'b0;
    end else if (!en || mode != MODE_1A) begin
      ptse_q <= 1'b0;
    end else if (wr && paddr == OFF_MCTRL) begin
      ptse_q <= pwdata[MC_PTSE];
    end
  end

  // Alternating reload source A then B in modes 1 and 1a
  // Disabling restarts the order at A
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel1_q <= 1'b0;
    end else if (!en) begin
      sel1_q <= 1'b0;
    end else if (uf1) begin
      sel1_q <= ~sel1_q;
    end
  end

  // ------------------------------------------------------------------
  // Primary pin output
  // ------------------------------------------------------------------
  // Output-level write sets the pin; underflow toggles it outside mode 2
  // The level write wins over a toggle in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level_q <= 1'b0;
    end else if (wr && paddr == OFF_MCTRL) begin
      pin_level_q <= pwdata[MC_AOUT];
    end else if (uf1 && aen && mode != MODE_2) begin
      pin_level_q <= ~pin_level_q;
    end
  end

  // Drive only where the pin is a waveform output
  // Released in mode 2, where the pin is a capture input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_timer_pin_o <= 1'b0;
      primary_timer_pin_oe <= 1'b0;
    end else begin
      primary_timer_pin_o <= pin_level_q;
      primary_timer_pin_oe <= aen && (mode != MODE_2);
    end
  end

  // ------------------------------------------------------------------
  // Pending flags: a new event wins over a same-cycle clear
  // ------------------------------------------------------------------
  logic [3:0] set_pnd, clr_pnd;
  logic uf1_a, uf1_b;
  assign uf1_a = uf1 && !(sel1_q && (mode == MODE_1 || mode == MODE_1A));
  assign uf1_b = uf1 && sel1_q && (mode == MODE_1 || mode == MODE_1A);
  assign set_pnd[0] = (mode == MODE_2) ? (en && a_edge) : uf1_a;
  // Flag B: capture in modes 2 and 4, never in mode 3
  assign set_pnd[1] = (mode == MODE_2 || mode == MODE_4) ?
                      (en && b_edge) : (mode == MODE_3 ? 1'b0 : uf1_b);
  // Flag C exists in mode 2 only
  assign set_pnd[2] = (mode == MODE_2) && uf1;
  assign set_pnd[3] = uf2;
  assign clr_pnd = (wr && paddr == OFF_ICLR) ? pwdata[3:0] : 4'h0;

  // Set term ORed after the clear, so an event is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_q <= 4'h0;
    end else begin
      pending_q <= (pending_q & ~clr_pnd) | set_pnd;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt lines
  // ------------------------------------------------------------------
  // Lines registered so the outputs come straight from flops
  // Cost: one cycle of lag behind the pending flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_line_one <= 1'b0;
      irq_line_two <= 1'b0;
    end else begin
      irq_line_one <= |(pending_q[2:0] & source_interrupt_enable_q[2:0]);
      irq_line_two <= pending_q[3] & source_interrupt_enable_q[3];
    end
  end

  // ------------------------------------------------------------------
  // APB slave: zero wait states, unmapped reads zero
  // ------------------------------------------------------------------
  // Offsets only: the base address is decoded outside, so both
  // instances answer the same map at their own base
  // Read data is latched in the setup cycle and stands with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > OFF_ICLR || paddr[1:0] != 2'h0);
      if (rd_en) begin
        case (paddr)
          OFF_CNT1: prdata <= {16'h0000, counter_one_q};
          OFF_CRA: prdata <= {16'h0000, reload_register_a_q};
          OFF_CRB: prdata <= {16'h0000, reload_register_b_q};
          OFF_CNT2: prdata <= {16'h0000, counter_two_q};
          OFF_PRSC: prdata <= {24'h000000, prescaler_value_q};
          OFF_CKC: prdata <= {26'h0000000, clock_mode_select_q};
          OFF_MCTRL: prdata <= {22'h000000, mode_control_bits_q[9:8],
                                ptse_q, pin_level_q, mode_control_bits_q[5:0]};
          OFF_ICTRL: prdata <= {24'h000000, pending_q,
                                source_interrupt_enable_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : mft_unit

`default_nettype wire

// [test/pad_model.sv]
// Pad model: GPIO pads carrying capture inputs and the waveform
`timescale 1ns/1ps
`default_nettype none
module pad_model (
  input wire logic pad_a_lvl, // External level on primary pad
  input wire logic pad_b_lvl, // External level on secondary pad
  input wire logic pin_o,     // Waveform level from the unit
  input wire logic pin_oe,    // Unit drives primary pad
  output logic pin_a_i,       // Primary level seen by unit
  output logic pin_b_i        // Secondary level seen by unit
);
  // Driven pad shows the waveform, else the outside level
  assign pin_a_i = pin_oe ? pin_o : pad_a_lvl;
  // Selected capture pad routed straight through
  assign pin_b_i = pad_b_lvl;
endmodule : pad_model
`default_nettype wire

// [test/mft_unit_chk.sv]
// Checker: bus handshake and interrupt line properties
`timescale 1ns/1ps
`default_nettype none
module mft_unit_chk import mft_pkg::*; (
  input wire logic pclk,            // Clock
  input wire logic presetn,         // Reset, active low
  input wire logic psel,            // Select
  input wire logic penable,         // Enable
  input wire logic pwrite,          // Direction
  input wire logic [7:0] paddr,     // Address
  input wire logic [31:0] pwdata,   // Write data
  input wire logic [31:0] prdata,   // Read data
  input wire logic pready,          // Ready
  input wire logic pslverr,         // Error
  input wire logic primary_timer_pin_oe, // Pad drive
  input wire logic irq_line_one,    // Line one
  input wire logic irq_line_two     // Line two
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // Assertions
  // ----
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_ERR_DECODE: assert property (pready |->
    pslverr == (paddr > OFF_ICLR || paddr[1:0] != 2'b00))
    else $error("error decode wrong");
  AST_ERR_ONLY_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_UNMAPPED_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_IRQ_OFF: assert property (pready && pwrite && paddr == OFF_ICTRL &&
    pwdata[3:0] == 4'h0 |=> ##1 !irq_line_one && !irq_line_two)
    else $error("line high with sources masked");
  AST_RESET_QUIET: assert property ($rose(presetn) |-> !pready &&
    !irq_line_one && !irq_line_two && !primary_timer_pin_oe)
    else $error("outputs active after reset");
  // Main scenarios reached
  COV_ERR: cover property (pready && pslverr);
  COV_IRQ_ONE: cover property ($rose(irq_line_one));
  COV_IRQ_TWO: cover property ($rose(irq_line_two));
endmodule : mft_unit_chk
bind mft_unit mft_unit_chk mft_unit_chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .primary_timer_pin_oe(primary_timer_pin_oe),
  .irq_line_one(irq_line_one), .irq_line_two(irq_line_two));
`default_nettype wire

// [test/mft_unit_bench.sv]
// Bench: register, pin and interrupt scenarios of one timer unit
`timescale 1ns/1ps
`default_nettype none
module mft_unit_bench import mft_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pa_i, pa_o, pa_oe, pb_i, pad_a, pad_b, irq1, irq2;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int t;
  mft_unit mft_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .primary_timer_pin_i(pa_i), .primary_timer_pin_o(pa_o),
    .primary_timer_pin_oe(pa_oe), .secondary_timer_pin_i(pb_i),
    .irq_line_one(irq1), .irq_line_two(irq2));
  pad_model pad_model_i (.pad_a_lvl(pad_a), .pad_b_lvl(pad_b),
    .pin_o(pa_o), .pin_oe(pa_oe), .pin_a_i(pa_i), .pin_b_i(pb_i));
  // ----
  // Clock and hang guard
  // ----
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // A stuck handshake must not hang the run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  // ----
  // Shared tasks
  // ----
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task give_verdict();
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // Request held until pready is sampled high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the hang guard ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rdchk
  // Pad pulse three cycles wide, b selects the secondary pad
  task pulse(input logic b);
    @(posedge pclk);
    if (b) pad_b <= 1'b1;
    else pad_a <= 1'b1;
    repeat (3) @(posedge pclk);
    pad_a <= 1'b0;
    pad_b <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse
  task count_tog(input int n);
    logic last;
    t = 0;
    @(negedge pclk);
    last = pa_o;
    repeat (n) begin
      @(negedge pclk);
      if (pa_o !== last) t++;
      last = pa_o;
    end
  endtask : count_tog
  // ----
  // Scenarios
  // ----
  task s_regs();
    rdchk("mode reset", OFF_MCTRL, 32'h0);
    rdchk("irq ctrl reset", OFF_ICTRL, 32'h0);
    apb(1'b1, OFF_PRSC, 32'h000000AB);
    rdchk("prescaler", OFF_PRSC, 32'hAB);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    apb(1'b0, 8'h02, 32'h0);
    chk("unaligned err", {31'h0, er}, 32'h1);
    apb(1'b1, OFF_PRSC, 32'h0);
    apb(1'b1, OFF_MCTRL, 32'h0A);
    apb(1'b1, OFF_CRA, 32'h1111);
    apb(1'b1, OFF_MCTRL, 32'h02);
    apb(1'b1, OFF_CRA, 32'h2222);
    rdchk("reload a", OFF_CRA, 32'h1111);
  endtask : s_regs
  task s_toggle();
    apb(1'b1, OFF_MCTRL, 32'h5A);
    repeat (2) @(posedge pclk);
    chk("level high", {31'h0, pa_o}, 32'h1);
    apb(1'b1, OFF_MCTRL, 32'h1A);
    apb(1'b1, OFF_CRA, 32'h3);
    apb(1'b1, OFF_CNT1, 32'h3);
    apb(1'b1, OFF_CRB, 32'h2);
    apb(1'b1, OFF_CNT2, 32'h2);
    apb(1'b1, OFF_ICLR, 32'hF);
    apb(1'b1, OFF_ICTRL, 32'hF);
    apb(1'b1, OFF_CKC, 32'h09);
    count_tog(40);
    chk("toggles", {31'h0, t >= 8 && t <= 14}, 32'h1);
    chk("line one", {31'h0, irq1}, 32'h1);
    chk("line two", {31'h0, irq2}, 32'h1);
    apb(1'b1, OFF_CKC, 32'h0);
    rdchk("pending", OFF_ICTRL, 32'h9F);
    apb(1'b1, OFF_ICLR, 32'hF);
    rdchk("cleared", OFF_ICTRL, 32'h0F);
    chk("line one off", {31'h0, irq1}, 32'h0);
    apb(1'b1, OFF_MCTRL, 32'h0A);
    apb(1'b1, OFF_CKC, 32'h09);
    count_tog(40);
    chk("no toggle", t, 32'h0);
    chk("no drive", {31'h0, pa_oe}, 32'h0);
    apb(1'b1, OFF_CKC, 32'h0);
    apb(1'b1, OFF_ICTRL, 32'h0);
  endtask : s_toggle
  task s_capture();
    apb(1'b1, OFF_ICLR, 32'hF);
    apb(1'b1, OFF_MCTRL, 32'h319);
    apb(1'b1, OFF_CKC, 32'h01);
    apb(1'b1, OFF_CNT1, 32'h0100);
    repeat (5) @(posedge pclk);
    rdchk("count held", OFF_CNT1, 32'h0100);
    pulse(1'b0);
    rdchk("capture a", OFF_CRA, 32'h0100);
    apb(1'b0, OFF_CNT1, 32'h0);
    chk("preset", rd[31:8], 24'h0000FF);
    pulse(1'b1);
    apb(1'b0, OFF_CRB, 32'h0);
    chk("capture b", rd[31:8], 24'h0000FF);
    rdchk("pending", OFF_ICTRL, 32'h30);
    apb(1'b1, OFF_MCTRL, 32'h20B);
    apb(1'b1, OFF_CKC, 32'h08);
    apb(1'b1, OFF_CNT2, 32'h0050);
    pulse(1'b1);
    rdchk("capture two", OFF_CRB, 32'h0050);
    apb(1'b0, OFF_CNT2, 32'h0);
    chk("no preset", rd[31:8], 24'h0);
  endtask : s_capture
  // Event clock, reload order, train hold and preset captures
  task s_modes();
    apb(1'b1, OFF_MCTRL, 32'h200);
    apb(1'b1, OFF_MCTRL, 32'h208);
    apb(1'b1, OFF_CRA, 32'h5);
    apb(1'b1, OFF_CRB, 32'h7);
    apb(1'b1, OFF_CNT1, 32'h0);
    apb(1'b1, OFF_CKC, 32'h02);
    apb(1'b1, OFF_ICLR, 32'hF);
    pulse(1'b1);
    rdchk("event reload a", OFF_CNT1, 32'h5);
    rdchk("flag a only", OFF_ICTRL, 32'h10);
    apb(1'b1, OFF_CNT1, 32'h0);
    pulse(1'b1);
    rdchk("event reload b", OFF_CNT1, 32'h7);
    rdchk("flag b", OFF_ICTRL, 32'h30);
    apb(1'b1, OFF_MCTRL, 32'h20C);
    apb(1'b1, OFF_MCTRL, 32'h28C);
    apb(1'b1, OFF_CNT1, 32'h3);
    pulse(1'b1);
    rdchk("train holds", OFF_CNT1, 32'h3);
    apb(1'b1, OFF_MCTRL, 32'h20C);
    pulse(1'b1);
    rdchk("train idle", OFF_CNT1, 32'h2);
    apb(1'b1, OFF_MCTRL, 32'h229);
    apb(1'b1, OFF_CKC, 32'h01);
    apb(1'b1, OFF_ICLR, 32'hF);
    apb(1'b1, OFF_CNT1, 32'h40);
    pulse(1'b1);
    rdchk("second to a", OFF_CRA, 32'h40);
    apb(1'b0, OFF_CNT1, 32'h0);
    chk("second preset", rd[31:8], 24'h0000FF);
    apb(1'b1, OFF_CNT1, 32'h3);
    repeat (8) @(posedge pclk);
    rdchk("flag c", OFF_ICTRL, 32'h60);
    apb(1'b1, OFF_MCTRL, 32'h22B);
    apb(1'b1, OFF_CKC, 32'h08);
    apb(1'b1, OFF_CNT2, 32'h30);
    pulse(1'b1);
    rdchk("capture two b", OFF_CRB, 32'h30);
    apb(1'b0, OFF_CNT2, 32'h0);
    chk("preset two", rd[31:8], 24'h0000FF);
    apb(1'b1, OFF_MCTRL, 32'h0);
  endtask : s_modes
  // ----
  // Main sequence
  // ----
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pad_a = 1'b0;
    pad_b = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_toggle();
    s_capture();
    s_modes();
    give_verdict();
  end
endmodule : mft_unit_bench
`default_nettype wire
